//--- design/ext_bus_map.svh
// constants for the external bus pin block
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
`define ADDR_W           24
`define DATA_W           32
`define RESET_VEC_ADDR   24'h00_0000
`define SYNC_STAGES      3
`define SHZ_ADDR_RST     24'h00_0000
`endif

//--- design/ext_bus_pkg.sv
// types shared by the external bus pin block
package ext_bus_pkg;
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_VEC   = 3'b001,
    ST_IDLE  = 3'b010,
    ST_ACC   = 3'b011,
    ST_HELD  = 3'b100,
    ST_SHUT  = 3'b101
  } bus_state_t;
endpackage : ext_bus_pkg

//--- design/pin_sync.sv
// three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
  // only the second and third flops are compared; the first is metastable
  always_comb begin
    lvl_d = lvl_q;
    if (s2_q == s3_q) begin
      lvl_d = s3_q;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end
  assign level_o = lvl_q;
endmodule : pin_sync

//--- design/ext_bus_pins.sv
// primary external bus pin control: access, hold, shutdown, ack, flags
//
// Contract
// - direction output high on reads, low on writes.
// - hold low suspends accesses unless the ignore bit is set.
// - grant acknowledge answers a low hold request.
// - no execution while reset is low.
// - after reset, the first access fetches the reset vector.
// - shutdown low floats every pin.
// - shutdown may discard internal state.
// - service acknowledge pulses on the acknowledge instruction.
// - two flag pins serve as general I/O or interlock signals.
// - bus outputs float on shutdown, hold grant or reset as marked.
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module ext_bus_pins #(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W
) (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  // core side
  input  wire logic                 req_i,
  input  wire logic                 req_write_i,
  input  wire logic [ADDR_W-1:0]    req_addr_i,
  output logic                      req_ready_o,
  output logic                      done_o,
  output logic                      vec_fetch_o,
  output logic                      run_o,
  input  wire logic                 request_ignore_bit_i,
  input  wire logic                 ack_instr_i,
  input  wire logic [1:0]           flag_out_i,
  input  wire logic [1:0]           flag_dir_out_i,
  output logic      [1:0]           flag_in_o,
  // pins
  output logic      [ADDR_W-1:0]    address_bus_o,
  output logic                      address_bus_oe_n_o,
  output logic                      rd_wr_n_o,
  output logic                      rd_wr_n_oe_n_o,
  output logic                      access_strobe_n_o,
  output logic                      access_strobe_n_oe_n_o,
  input  wire logic                 ready_n_i,
  input  wire logic                 hold_req_n_i,
  output logic                      bus_grant_ack_n_o,
  output logic                      bus_grant_ack_n_oe_n_o,
  input  wire logic                 shutdown_tristate_n_i,
  output logic                      service_ack_out_o,
  output logic                      service_ack_out_oe_n_o,
  input  wire logic [1:0]           external_flag_pins_i,
  output logic      [1:0]           external_flag_pins_o,
  output logic      [1:0]           external_flag_pins_oe_n_o
);
  import ext_bus_pkg::*;

  initial begin
    if (ADDR_W < 1 || ADDR_W > `ADDR_W) $error("ADDR_W out of range");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic rdy_n_s, hold_n_s, shz_n_s;
  logic [1:0] flag_s;
  pin_sync #(.RST_VAL(1'b1)) u_rdy  (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .pin_i(ready_n_i), .level_o(rdy_n_s));
  pin_sync #(.RST_VAL(1'b1)) u_hold (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .pin_i(hold_req_n_i), .level_o(hold_n_s));
  pin_sync #(.RST_VAL(1'b1)) u_shz  (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .pin_i(shutdown_tristate_n_i), .level_o(shz_n_s));
  pin_sync #(.RST_VAL(1'b0)) u_f0   (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .pin_i(external_flag_pins_i[0]), .level_o(flag_s[0]));
  pin_sync #(.RST_VAL(1'b0)) u_f1   (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .pin_i(external_flag_pins_i[1]), .level_o(flag_s[1]));

  // ------------------------------------------------------------
  // bus state machine
  // ------------------------------------------------------------
  bus_state_t        st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              wr_q, wr_d;
  logic              service_ack_out_q, service_ack_out_d;
  logic [1:0]        fo_q, fo_d, fdir_q, fdir_d;
  logic              hold_on;

  assign hold_on = !hold_n_s && !request_ignore_bit_i;

  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    wr_d   = wr_q;
    service_ack_out_d = 1'b0;
    fo_d   = flag_out_i;
    fdir_d = flag_dir_out_i;
    case (st_q)
      ST_RESET: begin
        st_d   = ST_VEC;
        addr_d = ADDR_W'(`RESET_VEC_ADDR);
        wr_d   = 1'b0;
      end
      // vector fetch is the first read
      ST_VEC: begin
        // hold waits for the fetch to end so the strobe never drops mid-cycle
        if (!rdy_n_s) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // a stale ready from the last access must clear before the next starts
        if (hold_on) begin
          st_d = ST_HELD;
        end else if (req_i && rdy_n_s) begin
          st_d   = ST_ACC;
          addr_d = req_addr_i;
          wr_d   = req_write_i;
        end
      end
      ST_ACC: begin
        if (!rdy_n_s) begin
          st_d = ST_IDLE;
        end
      end
      ST_HELD: begin
        if (!hold_on) begin
          st_d = ST_IDLE;
        end
      end
      ST_SHUT: begin
        st_d = ST_SHUT;
      end
      default: begin
        st_d = ST_RESET;
      end
    endcase
    if (ack_instr_i && st_q != ST_RESET) begin
      service_ack_out_d = 1'b1;
    end
    // shutdown forces ST_SHUT and clears the ack pulse; only reset leaves it
    if (!shz_n_s) begin
      st_d   = ST_SHUT;
      service_ack_out_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q   <= ST_RESET;
      addr_q <= '0;
      wr_q   <= 1'b0;
      service_ack_out_q <= 1'b0;
      fo_q   <= 2'h0;
      fdir_q <= 2'h0;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
      wr_q   <= wr_d;
      service_ack_out_q <= service_ack_out_d;
      fo_q   <= fo_d;
      fdir_q <= fdir_d;
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  logic active, float_bus, shut;
  assign active = (st_q == ST_VEC) || (st_q == ST_ACC);
  assign shut   = (st_q == ST_SHUT) || !shz_n_s;
  // float on shutdown, hold grant or reset
  assign float_bus = shut || (st_q == ST_HELD) || (st_q == ST_RESET);

  assign address_bus_o          = addr_q;
  assign address_bus_oe_n_o     = float_bus;
  assign rd_wr_n_o              = !wr_q;
  assign rd_wr_n_oe_n_o         = float_bus;
  // strobe low during access; strobe floats only on shutdown/hold
  assign access_strobe_n_o      = !active;
  assign access_strobe_n_oe_n_o = shut || (st_q == ST_HELD);
  assign bus_grant_ack_n_o      = !(st_q == ST_HELD);
  assign bus_grant_ack_n_oe_n_o = shut;
  assign service_ack_out_o      = !service_ack_out_q;
  assign service_ack_out_oe_n_o = shut;
  assign external_flag_pins_o      = fo_q;
  assign external_flag_pins_oe_n_o = (shut || st_q == ST_RESET) ? 2'h3 : ~fdir_q;
  assign flag_in_o                 = flag_s;

  assign req_ready_o = (st_q == ST_IDLE) && !hold_on && shz_n_s && rdy_n_s;
  assign done_o      = active && !rdy_n_s && shz_n_s;
  assign vec_fetch_o = (st_q == ST_VEC);
  assign run_o       = !(st_q == ST_RESET || st_q == ST_SHUT);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_acc_start;
    req_ready_o && req_i;
  endsequence

  strobe_access_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_acc_start |=> !access_strobe_n_o) else $error("strobe not low at access");
  dir_read_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_acc_start |=> rd_wr_n_o == !$past(req_write_i)) else $error("direction wrong");
  wait_ready_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_q == ST_ACC && rdy_n_s && shz_n_s) |=> st_q == ST_ACC) else $error("no wait");
  hold_grant_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_q == ST_IDLE && hold_on && shz_n_s) |=> !bus_grant_ack_n_o)
    else $error("no grant");
  hold_float_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !bus_grant_ack_n_o |-> address_bus_oe_n_o && rd_wr_n_oe_n_o) else $error("bus driven");
  shut_float_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !shz_n_s |-> service_ack_out_oe_n_o && access_strobe_n_oe_n_o
      && external_flag_pins_oe_n_o == 2'h3) else $error("pin driven in shutdown");
  service_ack_out_pulse_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ack_instr_i && run_o && shz_n_s) |=> !service_ack_out_o) else $error("no ack");
  vec_first_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_q == ST_RESET && shz_n_s) |=> vec_fetch_o && address_bus_o == '0)
    else $error("vector fetch missing");
  ready_done_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    done_o |-> !rdy_n_s ##1 access_strobe_n_o) else $error("access not closed on ready");
  ignore_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_q == ST_IDLE && request_ignore_bit_i && shz_n_s) |=> st_q != ST_HELD)
    else $error("hold not ignored");
endmodule : ext_bus_pins

//--- tb/mem_model.sv
// external memory model answering strobed accesses after a set wait count
`timescale 1ns/1ps
module mem_model (
  input  wire logic       clk_i,
  input  wire logic       strobe_n_i,
  input  wire logic [3:0] wait_i,
  output logic            ready_n_o
);
  logic [3:0] cnt_q = 4'h0;
  initial ready_n_o = 1'b1;
  always @(posedge clk_i) begin
    if (strobe_n_i) begin
      cnt_q <= 4'h0;
      ready_n_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      ready_n_o <= (cnt_q < wait_i);
    end
  end
endmodule : mem_model

//--- tb/testbench.sv
// self-checking bench for the external bus pin block
`timescale 1ns/1ps
`include "ext_bus_map.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module testbench;
  logic clk_i = 0, arst_n_i = 0, req_i = 0, req_write_i = 0, request_ignore_bit_i = 0;
  logic ack_instr_i = 0, hold_req_n_i = 1, shutdown_tristate_n_i = 1, ready_n_i;
  logic [23:0] req_addr_i = 24'h00_0000, address_bus_o;
  logic [1:0] flag_out_i = 0, flag_dir_out_i = 0, flag_drv = 0, flag_in_o;
  logic [1:0] external_flag_pins_i, external_flag_pins_o, external_flag_pins_oe_n_o;
  logic [3:0] wait_cnt = 4'h1;
  logic req_ready_o, done_o, vec_fetch_o, run_o, address_bus_oe_n_o, rd_wr_n_o, rd_wr_n_oe_n_o;
  logic access_strobe_n_o, access_strobe_n_oe_n_o, bus_grant_ack_n_o, bus_grant_ack_n_oe_n_o;
  logic service_ack_out_o, service_ack_out_oe_n_o;
  int bad_count = 0, check_count = 0, cyc_q = 0, n;

  always #2 clk_i = ~clk_i;
  // floated flag bits read what the board drives
  assign external_flag_pins_i = (external_flag_pins_oe_n_o & flag_drv)
                              | (~external_flag_pins_oe_n_o & external_flag_pins_o);

  ext_bus_pins dut_u (.clk_i, .arst_n_i, .req_i, .req_write_i, .req_addr_i, .req_ready_o,
    .done_o, .vec_fetch_o, .run_o, .request_ignore_bit_i, .ack_instr_i, .flag_out_i,
    .flag_dir_out_i, .flag_in_o, .address_bus_o, .address_bus_oe_n_o, .rd_wr_n_o,
    .rd_wr_n_oe_n_o, .access_strobe_n_o, .access_strobe_n_oe_n_o, .ready_n_i, .hold_req_n_i,
    .bus_grant_ack_n_o, .bus_grant_ack_n_oe_n_o, .shutdown_tristate_n_i, .service_ack_out_o,
    .service_ack_out_oe_n_o, .external_flag_pins_i, .external_flag_pins_o,
    .external_flag_pins_oe_n_o);
  mem_model mem_u (.clk_i(clk_i), .strobe_n_i(access_strobe_n_o), .wait_i(wait_cnt),
    .ready_n_o(ready_n_i));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  always @(posedge clk_i) begin
    cyc_q++;
    if (cyc_q == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic reset_vec();
    arst_n_i = 1'b0;
    repeat (20) @(negedge clk_i);
    `CHK("rst_oe", 2'b11, {address_bus_oe_n_o, rd_wr_n_oe_n_o})
    `CHK("rst_soe", 1'b0, access_strobe_n_oe_n_o)
    `CHK("rst_run", 1'b0, run_o)
    `CHK("rst_access_strobe_n", 1'b1, access_strobe_n_o)
    arst_n_i = 1'b1;
    n = 0;
    while (vec_fetch_o !== 1'b1 && n < 20) begin @(negedge clk_i); n++; end
    `CHK("vec_fetch", 1'b1, vec_fetch_o)
    `CHK("vec_addr", `RESET_VEC_ADDR, address_bus_o)
    `CHK("vec_rd", 1'b1, rd_wr_n_o)
    `CHK("vec_access_strobe_n", 1'b0, access_strobe_n_o)
    while (done_o !== 1'b1 && n < 40) begin @(negedge clk_i); n++; end
    `CHK("vec_done", 1'b1, done_o)
    repeat (4) @(negedge clk_i);
    `CHK("run", 1'b1, run_o)
    $display("test reset_vec done");
  endtask : reset_vec

  // ready reaches the block one model cycle plus the synchroniser after the wait count
  task automatic access(input logic wr, input logic [23:0] ad);
    req_i = 1'b1;
    req_write_i = wr;
    req_addr_i = ad;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 50) begin @(negedge clk_i); n++; end
    `CHK("req_rdy", 1'b1, req_ready_o)
    @(negedge clk_i);
    req_i = 1'b0;
    `CHK("dir", ~wr, rd_wr_n_o)
    `CHK("addr", ad, address_bus_o)
    `CHK("addr_oe", 1'b0, address_bus_oe_n_o)
    n = 0;
    while (done_o !== 1'b1 && n < 50) begin
      `CHK("access_strobe_n", 1'b0, access_strobe_n_o)
      @(negedge clk_i);
      n++;
    end
    `CHK("done", 1'b1, done_o)
    `CHK("waits", wait_cnt + `SYNC_STAGES + 2, n)
    repeat (4) @(negedge clk_i);
    `CHK("access_strobe_n_end", 1'b1, access_strobe_n_o)
  endtask : access

  task automatic hold_test();
    hold_req_n_i = 1'b0;
    n = 0;
    while (bus_grant_ack_n_o !== 1'b0 && n < 20) begin @(negedge clk_i); n++; end
    `CHK("grant", 1'b0, bus_grant_ack_n_o)
    `CHK("grant_oe", 1'b0, bus_grant_ack_n_oe_n_o)
    `CHK("hold_oe", 3'h7, {address_bus_oe_n_o, rd_wr_n_oe_n_o, access_strobe_n_oe_n_o})
    `CHK("hold_rdy", 1'b0, req_ready_o)
    request_ignore_bit_i = 1'b1;
    access(1'b1, 24'h12_3456);
    `CHK("ign_grant", 1'b1, bus_grant_ack_n_o)
    // release the pin first so dropping the ignore bit cannot re-grant
    hold_req_n_i = 1'b1;
    repeat (8) @(negedge clk_i);
    request_ignore_bit_i = 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK("release", 1'b1, bus_grant_ack_n_o)
    $display("test hold done");
  endtask : hold_test

  task automatic ack_flag_test();
    flag_dir_out_i = 2'b01;
    flag_out_i = 2'b11;
    flag_drv = 2'b10;
    ack_instr_i = 1'b1;
    @(negedge clk_i);
    ack_instr_i = 1'b0;
    n = (service_ack_out_o === 1'b0);
    repeat (5) begin @(negedge clk_i); n += (service_ack_out_o === 1'b0); end
    `CHK("ack_pulse", 1, n)
    `CHK("flag_oe", 2'b10, external_flag_pins_oe_n_o)
    `CHK("flag_out", 1'b1, external_flag_pins_o[0])
    `CHK("flag_in", 2'b11, flag_in_o)
    $display("test ack_flag done");
  endtask : ack_flag_test

  task automatic shut_test();
    shutdown_tristate_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    `CHK("shz_oe", 7'h7F, {address_bus_oe_n_o, rd_wr_n_oe_n_o, access_strobe_n_oe_n_o,
      bus_grant_ack_n_oe_n_o, service_ack_out_oe_n_o, external_flag_pins_oe_n_o})
    `CHK("shz_rdy", 1'b0, req_ready_o)
    shutdown_tristate_n_i = 1'b1;
    reset_vec();
    $display("test shutdown done");
  endtask : shut_test

  initial begin
    reset_vec();
    access(1'b1, 24'hFF_FFFF);
    wait_cnt = 4'h6;
    access(1'b0, 24'h5A_A5A5);
    $display("test access done");
    hold_test();
    ack_flag_test();
    shut_test();
    end_sim();
  end
endmodule : testbench
